// [dv/rxd_host_model.sv]
// system memory side that takes descriptor status word writes
`timescale 1ns/100ps
module rxd_host_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] stall,
  input wire logic wbValid,
  input wire logic [31:0] wbAddr,
  input wire logic [31:0] wbData,
  output logic wbReady_ff,
  output logic [15:0] wrCnt_ff,
  output logic [31:0] lastAddr_ff,
  output logic [31:0] lastWord_ff
);
  logic [3:0] waitCnt_ff; // cycles the pending write has waited
  // *****
  // accept logic
  // *****
  // ready after stall cycles, one beat only, so slow memory is modelled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wbReady_ff <= 1'h0;
      waitCnt_ff <= 4'h0;
      wrCnt_ff <= 16'h0;
    end else if (wbReady_ff) begin
      // word 0 of each 16-byte slot taken whole in one beat
      wbReady_ff <= 1'h0;
      waitCnt_ff <= 4'h0;
      wrCnt_ff <= wrCnt_ff + 16'h1;
      lastAddr_ff <= wbAddr;
      lastWord_ff <= wbData;
    end else if (wbValid) begin
      if (waitCnt_ff >= stall) begin
        wbReady_ff <= 1'h1;
      end else begin
        waitCnt_ff <= waitCnt_ff + 4'h1;
      end
    end
  end
endmodule

// [dv/rxd_status_writeback_checker.sv]
// concurrent checks on the ports of the status writeback block
`timescale 1ns/100ps
module rxd_status_writeback_checker
  import rxd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic frameEnd,
  input wire logic bufFull,
  input wire logic descOwned,
  input wire logic descIrqSuppress,
  input wire logic wbValid_ff,
  input wire logic [31:0] wbAddr_ff,
  input wire logic [31:0] wbData_ff,
  input wire logic wbReady,
  input wire logic rxComplete_ff
);
  // *****
  // sequences
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // write taken by memory this edge
  sequence s_accept;
    wbValid_ff && wbReady;
  endsequence
  // write pending, memory stalling
  sequence s_stall;
    wbValid_ff && !wbReady;
  endsequence
  // *****
  // assertions
  // *****
  a_setup_answer:
    assert property (psel && !penable |=> pready_ff)
    else $error("no ready after apb setup");
  a_ready_access:
    assert property (pready_ff |-> psel && penable)
    else $error("ready outside access phase");
  a_err_ready:
    assert property (pslverr_ff |-> pready_ff)
    else $error("slave error without ready");
  a_close_cause:
    assert property ($rose(wbValid_ff) |-> $past(frameEnd || bufFull)
      && $past(descOwned))
    else $error("write without owned close");
  a_owner_cleared:
    assert property (wbValid_ff |-> !wbData_ff[OWN_BIT])
    else $error("written word keeps ownership");
  a_err_summary:
    assert property (wbValid_ff && wbData_ff[LAST_BIT] |->
      wbData_ff[ERRSUM_BIT] == (|(wbData_ff & 32'h0000_48DA)))
    else $error("error summary wrong");
  a_wb_hold:
    assert property (s_stall |=> wbValid_ff && $stable(wbData_ff)
      && $stable(wbAddr_ff))
    else $error("write changed before accept");
  a_complete_after:
    assert property (s_accept ##0 (wbData_ff[LAST_BIT] && !descIrqSuppress)
      |=> rxComplete_ff ##1 !rxComplete_ff)
    else $error("complete pulse missing");
  a_complete_cause:
    assert property (rxComplete_ff |-> $past(wbValid_ff && wbReady
      && wbData_ff[LAST_BIT]))
    else $error("complete pulse without last close");
endmodule

bind rxd_status_writeback rxd_status_writeback_checker u_chk (
  .clk, .reset_n, .psel, .penable, .pready_ff, .pslverr_ff, .frameEnd,
  .bufFull, .descOwned, .descIrqSuppress, .wbValid_ff, .wbAddr_ff,
  .wbData_ff, .wbReady, .rxComplete_ff);

// [dv/rxd_status_writeback_tb.sv]
// self-checking bench for the status writeback block
`timescale 1ns/100ps
module rxd_status_writeback_tb
  import rxd_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF; // whole word compared
  localparam logic [31:0] LENX = 32'h8000_FFFF; // length ignored
  logic clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, frameStart = 1'h0, xferValid = 1'h0;
  logic bufFull = 1'h0, frameEnd = 1'h0, rxEr = 1'h0, rxDv = 1'h0;
  logic fifoOverflow = 1'h0, dafFail = 1'h0, safFail = 1'h0;
  logic lenMismatch = 1'h0, vlanTag = 1'h0, ipHdrErr = 1'h0;
  logic lateCollision = 1'h0, oddNibble = 1'h0, crcErr = 1'h0;
  logic pcsumErr = 1'h0, descIrqSuppress = 1'h0;
  logic descOwned = 1'h1, nextDescOwned = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] xferBytes = 3'h0;
  logic [15:0] typeField = 16'h05FF;
  logic [3:0] stall = 4'h0;
  logic [31:0] prdata_ff, wbAddr_ff, wbData_ff, lastAddr, lastWord, rd;
  logic [31:0] expAddr;
  logic pready_ff, pslverr_ff, wbValid_ff, wbReady, rxComplete_ff, err;
  logic [15:0] wrCnt;
  logic cut = 1'h0, drop = 1'h0; // flush stop, ownership loss
  int error_cnt = 0, checked = 0, seen = 0, expComp = 0, compCnt = 0;
  int cyc = 0;
  int bp[11] = '{11, 0, 1, 2, 6, 7, 10, 12, 13, 30, 3}; // flag bit spots
  logic [10:0] esum = 11'h435; // flags feeding the summary bit
  always #50 clk = ~clk;
  rxd_status_writeback dut (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff,
    .pready_ff, .pslverr_ff, .frameStart, .xferValid, .xferBytes, .bufFull,
    .frameEnd, .rxEr, .rxDv, .fifoOverflow, .dafFail, .safFail,
    .lenMismatch, .vlanTag, .ipHdrErr, .lateCollision, .typeField,
    .oddNibble, .crcErr, .pcsumErr, .descOwned, .nextDescOwned,
    .descIrqSuppress, .wbValid_ff, .wbAddr_ff, .wbData_ff, .wbReady,
    .rxComplete_ff);
  rxd_host_model host (
    .clk, .reset_n, .stall, .wbValid(wbValid_ff), .wbAddr(wbAddr_ff),
    .wbData(wbData_ff), .wbReady_ff(wbReady), .wrCnt_ff(wrCnt),
    .lastAddr_ff(lastAddr), .lastWord_ff(lastWord));
  // *****
  // tasks
  // *****
  task automatic close_out;
    $display("compares %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, mask);
    checked++;
    if ((got & mask) !== (exp & mask)) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready_ff !== 1'h1);
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // wait for one status write and compare it
  task automatic wait_wr(input logic [31:0] exp, mask);
    int n;
    n = 0;
    while (wrCnt == seen[15:0] && n < 100) begin
      @(posedge clk);
      n++;
    end
    seen = wrCnt;
    chk({31'h0, n < 100}, 32'h1, ALL);
    chk(lastWord, exp, mask);
    chk(lastAddr, expAddr, ALL);
    expAddr = expAddr + DESC_STRIDE;
    if (exp[LAST_BIT] && !descIrqSuppress)
      expComp++;
  endtask
  // n words of 4 bytes, buffer full before word b, flags f[9:1] at the end, f[10] and f[0] during the words
  task automatic frame(input int n, input int b, input logic [10:0] f);
    @(posedge clk);
    frameStart <= 1'h1;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      frameStart <= 1'h0;
      if (k == b) begin
        xferValid <= 1'h0;
        bufFull <= 1'h1;
        @(posedge clk);
        bufFull <= 1'h0;
        wait_wr(cut ? 32'h0000_C300 : {2'h0, 14'(k * 4), 16'h0200},
          cut ? LENX : ALL);
        if (cut)
          return;
        @(posedge clk);
      end
      xferValid <= 1'h1;
      xferBytes <= 3'h4;
      rxDv <= 1'h1;
      rxEr <= f[10] && k == 1;
      fifoOverflow <= f[0] && k > 0;
    end
    @(posedge clk);
    xferValid <= 1'h0;
    rxDv <= 1'h0;
    rxEr <= 1'h0;
    frameEnd <= 1'h1;
    descOwned <= !drop;
    {dafFail, safFail, lenMismatch, vlanTag, ipHdrErr, lateCollision,
      oddNibble, crcErr, pcsumErr} <= f[9:1];
    @(posedge clk);
    frameEnd <= 1'h0;
    fifoOverflow <= 1'h0;
  endtask
  // *****
  // timeout and pulse count
  // *****
  always @(posedge clk) begin
    cyc++;
    if (rxComplete_ff === 1'h1)
      compCnt++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // *****
  // tests
  // *****
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    apb(1'h0, REG_CTRL, 32'h0);
    chk(rd, 32'h0, ALL);
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1, ALL);
    apb(1'h1, REG_DESC_BASE, 32'h0000_1000);
    expAddr = 32'h0000_1000;
    apb(1'h1, REG_CTRL, 32'h0000_0019);
    for (int i = 0; i < 11; i++) begin
      frame(6, -1, 11'h1 << i);
      wait_wr(32'h0018_0300 | (32'h1 << bp[i]) | (32'(esum[i]) << 15),
        ALL);
    end
    typeField <= ETHERTYPE_MIN;
    frame(6, -1, 11'h0);
    wait_wr(32'h0018_0320, ALL);
    typeField <= 16'h05FF;
    $display("test flags done");
    frame(513, -1, 11'h0);
    wait_wr(32'h0000_8310, LENX);
    apb(1'h1, REG_CTRL, 32'h0000_001B);
    frame(513, -1, 11'h0);
    wait_wr(32'h0804_0300, ALL);
    frame(4097, -1, 11'h0);
    wait_wr(32'h0000_8310, LENX);
    $display("test watchdog done");
    stall <= 4'h3;
    frame(6, 3, 11'h0);
    wait_wr(32'h0018_0100, ALL);
    nextDescOwned <= 1'h0;
    cut = 1'h1;
    apb(1'h1, REG_CTRL, 32'h0000_001D);
    frame(6, 3, 11'h0);
    cut = 1'h0;
    nextDescOwned <= 1'h1;
    $display("test segments done");
    descIrqSuppress <= 1'h1;
    frame(6, -1, 11'h0);
    wait_wr(32'h0018_0300, ALL);
    descIrqSuppress <= 1'h0;
    drop = 1'h1;
    frame(6, -1, 11'h0);
    repeat (10) @(posedge clk);
    chk({16'h0, wrCnt}, seen, ALL);
    frameStart <= 1'h1;
    @(posedge clk);
    frameStart <= 1'h0;
    descOwned <= 1'h1;
    drop = 1'h0;
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd, 32'h7, 32'h7);
    apb(1'h1, REG_STATUS, 32'h7);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd, 32'h0, 32'h7);
    apb(1'h0, REG_DESC_PTR, 32'h0);
    chk(rd, expAddr, ALL);
    apb(1'h0, REG_FRAME_CNT, 32'h0);
    chk(rd, 32'h12, ALL);
    apb(1'h0, REG_LAST_WORD, 32'h0);
    chk(rd, 32'h0018_0300, ALL);
    chk(compCnt, expComp, ALL);
    $display("test status done");
    close_out();
  end
endmodule

// [hdl/rxd_byte_counter.sv]
// running byte count and receive watchdog of the current frame
`timescale 1ns/100ps
module rxd_byte_counter
  import rxd_pkg::*;
#(
  parameter int unsigned CNT_W = 15
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic addEn,
  input wire logic [2:0] addBytes,
  input wire logic wdSelect,
  output logic [CNT_W-1:0] count_ff,
  output logic wdTimeout_ff
);

  // the count must reach past the long watchdog limit
  if (CNT_W < 15) begin : g_bad_width
    $error("rxd_byte_counter: CNT_W below 15");
  end

  localparam logic [CNT_W-1:0] LIM_SHORT = CNT_W'(WD_LIMIT_SHORT);
  localparam logic [CNT_W-1:0] LIM_LONG = CNT_W'(WD_LIMIT_LONG);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  logic [CNT_W-1:0] nxt_count; // saturating sum
  logic [CNT_W-1:0] limit; // selected watchdog limit

  always_comb begin
    limit = wdSelect ? LIM_LONG : LIM_SHORT;
    nxt_count = count_ff + CNT_W'(addBytes);
    // saturate rather than wrap so a runaway frame stays flagged
    if (nxt_count < count_ff) begin
      nxt_count = CNT_MAX;
    end
  end

  // byte count, restarted at each frame start
  always_ff @(posedge clk) begin
    if (!reset_n || clear) begin
      count_ff <= '0;
    end else if (addEn) begin
      count_ff <= nxt_count;
    end
  end

  // watchdog: sticky once the frame runs past the limit
  always_ff @(posedge clk) begin
    if (!reset_n || clear) begin
      wdTimeout_ff <= 1'b0;
    end else if (count_ff > limit || (addEn && nxt_count > limit)) begin
      wdTimeout_ff <= 1'b1;
    end
  end

endmodule

// [hdl/rxd_pkg.sv]
// constants and types for the receive descriptor status writeback block
package rxd_pkg;

  // status word field positions
  localparam int unsigned OWN_BIT = 31;
  localparam int unsigned DAF_BIT = 30;
  localparam int unsigned LEN_LSB = 16;
  localparam int unsigned LEN_W = 14;
  localparam int unsigned ERRSUM_BIT = 15;
  localparam int unsigned DESCERR_BIT = 14;
  localparam int unsigned SAF_BIT = 13;
  localparam int unsigned LENERR_BIT = 12;
  localparam int unsigned OVF_BIT = 11;
  localparam int unsigned VLAN_BIT = 10;
  localparam int unsigned FIRST_BIT = 9;
  localparam int unsigned LAST_BIT = 8;
  localparam int unsigned IPHDR_BIT = 7;
  localparam int unsigned LATECOL_BIT = 6;
  localparam int unsigned ETYPE_BIT = 5;
  localparam int unsigned WDT_BIT = 4;
  localparam int unsigned PHYERR_BIT = 3;
  localparam int unsigned DRIBBLE_BIT = 2;
  localparam int unsigned CRC_BIT = 1;
  localparam int unsigned PCSUM_BIT = 0;

  // descriptor layout: four 32-bit words, 16 bytes apart
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;

  // frame limits
  localparam int unsigned WD_LIMIT_SHORT = 2048;
  localparam int unsigned WD_LIMIT_LONG = 16384;
  localparam logic [15:0] ETHERTYPE_MIN = 16'h0600;
  localparam int unsigned RUNT_BYTES = 14;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DESC_BASE = 8'h04;
  localparam logic [7:0] REG_DESC_PTR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_LAST_WORD = 8'h10;
  localparam logic [7:0] REG_FRAME_CNT = 8'h14;

  // control bits
  localparam int unsigned CTRL_RXEN = 0;
  localparam int unsigned CTRL_WDSEL = 1;
  localparam int unsigned CTRL_FLUSH = 2;
  localparam int unsigned CTRL_HALFDUP = 3;
  localparam int unsigned CTRL_MII = 4;
  localparam int unsigned CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // status bits, write one to clear
  localparam int unsigned STAT_COMPLETE = 0;
  localparam int unsigned STAT_UNAVAIL = 1;
  localparam int unsigned STAT_SKIPPED = 2;
  localparam int unsigned STAT_W = 3;

  // writeback sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECV,
    ST_WRITE,
    ST_WAITDESC
  } rxd_state_type;

endpackage

// [hdl/rxd_status_pack.sv]
// assembles and holds the descriptor status word for one writeback
`timescale 1ns/100ps
module rxd_status_pack
  import rxd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [LEN_W-1:0] lenField,
  input wire logic firstSeg,
  input wire logic lastSeg,
  input wire logic descErr,
  input wire logic dafFail,
  input wire logic safFail,
  input wire logic lenErr,
  input wire logic ovfErr,
  input wire logic vlan,
  input wire logic ipHdrErr,
  input wire logic lateCol,
  input wire logic ethType,
  input wire logic wdTimeout,
  input wire logic phyErr,
  input wire logic dribble,
  input wire logic crcErr,
  input wire logic pcsumErr,
  output logic [31:0] word_ff
);

  logic [31:0] nxt_word; // word to be written

  always_comb begin
    nxt_word = '0;
    nxt_word[OWN_BIT] = 1'b0;
    nxt_word[DAF_BIT] = dafFail;
    nxt_word[LEN_LSB +: LEN_W] = lenField;
    nxt_word[DESCERR_BIT] = descErr;
    nxt_word[SAF_BIT] = safFail;
    nxt_word[LENERR_BIT] = lenErr;
    nxt_word[OVF_BIT] = ovfErr;
    nxt_word[VLAN_BIT] = vlan;
    nxt_word[FIRST_BIT] = firstSeg;
    nxt_word[LAST_BIT] = lastSeg;
    nxt_word[IPHDR_BIT] = ipHdrErr;
    nxt_word[LATECOL_BIT] = lateCol;
    nxt_word[ETYPE_BIT] = ethType;
    nxt_word[WDT_BIT] = wdTimeout;
    nxt_word[PHYERR_BIT] = phyErr;
    nxt_word[DRIBBLE_BIT] = dribble;
    nxt_word[CRC_BIT] = crcErr;
    nxt_word[PCSUM_BIT] = pcsumErr;
    // summary is the OR of the serious errors
    nxt_word[ERRSUM_BIT] = descErr | ovfErr | ipHdrErr | lateCol |
                           wdTimeout | phyErr | crcErr;
  end

  // word is held stable for the whole write handshake
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_ff <= '0;
    end else if (load) begin
      word_ff <= nxt_word;
    end
  end

endmodule

// [hdl/rxd_status_writeback.sv]
// receive descriptor status writeback engine with APB control registers
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
module rxd_status_writeback
  import rxd_pkg::*;
#(
  parameter int unsigned CNT_W = 15
) (
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // frame data movement from the receive FIFO
  input wire logic frameStart,
  input wire logic xferValid,
  input wire logic [2:0] xferBytes,
  input wire logic bufFull,
  input wire logic frameEnd,
  // line signals watched during reception
  input wire logic rxEr,
  input wire logic rxDv,
  input wire logic fifoOverflow,
  // per-frame MAC results, valid with frameEnd
  input wire logic dafFail,
  input wire logic safFail,
  input wire logic lenMismatch,
  input wire logic vlanTag,
  input wire logic ipHdrErr,
  input wire logic lateCollision,
  input wire logic [15:0] typeField,
  input wire logic oddNibble,
  input wire logic crcErr,
  input wire logic pcsumErr,
  // ownership of current and next descriptor, from the fetch logic
  input wire logic descOwned,
  input wire logic nextDescOwned,
  input wire logic descIrqSuppress,
  // status word write toward system memory
  output logic wbValid_ff,
  output logic [31:0] wbAddr_ff,
  output logic [31:0] wbData_ff,
  input wire logic wbReady,
  // receive complete event toward the DMA status register
  output logic rxComplete_ff
);

  // ***********************************************************
  // declarations
  // ***********************************************************

  rxd_state_type state_ff; // writeback sequencer
  logic [CTRL_W-1:0] ctrl_ff; // control register
  logic [31:0] descBase_ff; // start of descriptor table
  logic [31:0] descPtr_ff; // current descriptor word 0 address
  logic [STAT_W-1:0] stat_ff; // sticky status flags
  logic [31:0] frameCnt_ff; // frames closed with last segment
  logic firstSeg_ff; // next close holds the frame start
  logic lastClose_ff; // pending write closes the frame
  logic stallAfter_ff; // wait for an owned descriptor after write
  logic suppress_ff; // completion suppressed for pending write
  logic phyErr_ff; // RX_ER seen with RX_DV this frame
  logic ovfErr_ff; // overflow after partial transfer
  logic [CNT_W-1:0] byteCount; // running byte count
  logic wdTimeout; // watchdog expired this frame

  logic apbSetup; // first cycle of a transfer
  logic apbWrite; // write takes effect now
  logic recvActive; // bytes are being moved
  logic closeEvt; // current descriptor must be closed
  logic closeLast; // the close ends the frame
  logic descErrNow; // buffer full and next not owned, flushing
  logic stallNow; // buffer full, next not owned, no flush
  logic packLoad; // capture the status word
  logic writeDone; // memory accepted the status word
  logic [LEN_W-1:0] lenField; // length field value
  logic ethType; // type field decode
  logic [STAT_W-1:0] statSet; // hardware set terms
  logic [STAT_W-1:0] statClr; // software clear terms

  // ***********************************************************
  // helpers
  // ***********************************************************

  // register read mux, also tells whether the offset is mapped
  function automatic logic [32:0] regRead(input logic [7:0] addr);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case (addr)
      REG_CTRL: r = {1'b1, 27'h0, ctrl_ff};
      REG_DESC_BASE: r = {1'b1, descBase_ff};
      REG_DESC_PTR: r = {1'b1, descPtr_ff};
      REG_STATUS: r = {1'b1, 29'h0, stat_ff};
      REG_LAST_WORD: r = {1'b1, wbData_ff};
      REG_FRAME_CNT: r = {1'b1, frameCnt_ff};
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  // ***********************************************************
  // APB slave
  // ***********************************************************

  // one wait-free access: answer is ready in the first access cycle
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && pready_ff;

  // pready rises for the access cycle that follows each setup
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= apbSetup;
    end
  end

  // read data and error are settled at setup so they come from flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else if (apbSetup) begin
      {pslverr_ff, prdata_ff} <= (regRead(paddr) & {1'b1, {32{!pwrite}}})
                                 ^ {1'b1, 32'h0000_0000}; // flag inverted
    end else begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RESET;
    end else if (apbWrite && paddr == REG_CTRL) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end
  end

  // table base; writing it also rewinds the descriptor pointer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      descBase_ff <= '0;
    end else if (apbWrite && paddr == REG_DESC_BASE) begin
      descBase_ff <= pwdata;
    end
  end

  // ***********************************************************
  // status flags
  // ***********************************************************

  // a hardware set in the same cycle as a software clear wins
  always_comb begin
    statSet = '0;
    statSet[STAT_COMPLETE] = writeDone && lastClose_ff && !suppress_ff;
    statSet[STAT_UNAVAIL] = (state_ff == ST_IDLE) && frameStart &&
                            ctrl_ff[CTRL_RXEN] && !descOwned;
    statSet[STAT_SKIPPED] = closeEvt && !descOwned;
    statClr = '0;
    if (apbWrite && paddr == REG_STATUS) begin
      statClr = pwdata[STAT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~statClr) | statSet;
    end
  end

  // one-cycle completion event; suppress bit is honoured
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxComplete_ff <= 1'b0;
    end else begin
      rxComplete_ff <= statSet[STAT_COMPLETE];
    end
  end

  // count of frames closed with a last segment
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frameCnt_ff <= '0;
    end else if (writeDone && lastClose_ff) begin
      frameCnt_ff <= frameCnt_ff + 32'h0000_0001;
    end
  end

  // ***********************************************************
  // close decisions
  // ***********************************************************

  assign recvActive = (state_ff == ST_RECV);
  assign closeEvt = recvActive && (frameEnd || bufFull);
  assign descErrNow = !frameEnd && bufFull && !nextDescOwned &&
                      ctrl_ff[CTRL_FLUSH];
  assign stallNow = !frameEnd && bufFull && !nextDescOwned &&
                    !ctrl_ff[CTRL_FLUSH];
  assign closeLast = frameEnd || descErrNow;
  // a descriptor read as software-owned is never written
  assign packLoad = closeEvt && descOwned;
  assign writeDone = wbValid_ff && wbReady;

  // count is the transferred bytes so far, CRC included
  assign lenField = byteCount[LEN_W-1:0];
  // type decode is forced off for runt frames
  assign ethType = (typeField >= ETHERTYPE_MIN) &&
                   (byteCount >= CNT_W'(RUNT_BYTES));

  // ***********************************************************
  // per-frame sticky errors
  // ***********************************************************

  // receive error only counts while data is valid on the line
  always_ff @(posedge clk) begin
    if (!reset_n || frameStart) begin
      phyErr_ff <= 1'b0;
    end else if (recvActive && rxEr && rxDv) begin
      phyErr_ff <= 1'b1;
    end
  end

  // overflow matters only once some bytes reached the buffer
  always_ff @(posedge clk) begin
    if (!reset_n || frameStart) begin
      ovfErr_ff <= 1'b0;
    end else if (recvActive && fifoOverflow && byteCount != '0) begin
      ovfErr_ff <= 1'b1;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************

  // idle -> recv per frame; each owned close goes through write, an unowned one returns to idle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          // a descriptor the host still owns is never used
          if (frameStart && ctrl_ff[CTRL_RXEN] && descOwned) begin
            state_ff <= ST_RECV;
          end
        end
        ST_RECV: begin
          if (packLoad) begin
            state_ff <= ST_WRITE;
          end else if (closeEvt) begin
            state_ff <= ST_IDLE; // unowned: abandon
          end
        end
        ST_WRITE: begin
          if (writeDone && lastClose_ff) begin
            state_ff <= ST_IDLE;
          end else if (writeDone && stallAfter_ff) begin
            state_ff <= ST_WAITDESC;
          end else if (writeDone) begin
            state_ff <= ST_RECV;
          end
        end
        ST_WAITDESC: begin
          // resume the same frame once software hands one back
          if (nextDescOwned) begin
            state_ff <= ST_RECV;
          end
        end
      endcase
    end
  end

  // segment bookkeeping captured at each owned close
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      firstSeg_ff <= 1'b0;
      lastClose_ff <= 1'b0;
      stallAfter_ff <= 1'b0;
      suppress_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && frameStart) begin
      firstSeg_ff <= 1'b1;
    end else if (packLoad) begin
      firstSeg_ff <= 1'b0;
      lastClose_ff <= closeLast;
      stallAfter_ff <= stallNow;
      suppress_ff <= descIrqSuppress;
    end
  end

  // descriptor pointer steps one whole descriptor per accepted status write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      descPtr_ff <= '0;
    end else if (apbWrite && paddr == REG_DESC_BASE) begin
      descPtr_ff <= pwdata;
    end else if (writeDone) begin
      descPtr_ff <= descPtr_ff + DESC_STRIDE;
    end
  end

  // memory write request held until accepted
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wbValid_ff <= 1'b0;
      wbAddr_ff <= '0;
    end else if (packLoad) begin
      wbValid_ff <= 1'b1;
      wbAddr_ff <= descPtr_ff; // status is word 0
    end else if (writeDone) begin
      wbValid_ff <= 1'b0;
    end
  end

  // ***********************************************************
  // leaf instances
  // ***********************************************************

  rxd_byte_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk(clk),
    .reset_n(reset_n),
    .clear(state_ff == ST_IDLE && frameStart),
    .addEn(recvActive && xferValid),
    .addBytes(xferBytes),
    .wdSelect(ctrl_ff[CTRL_WDSEL]),
    .count_ff(byteCount),
    .wdTimeout_ff(wdTimeout)
  );

  // frame-level flags only appear in the closing descriptor
  rxd_status_pack u_pack (
    .clk(clk),
    .reset_n(reset_n),
    .load(packLoad),
    .lenField(lenField),
    .firstSeg(firstSeg_ff),
    .lastSeg(closeLast),
    .descErr(descErrNow),
    .dafFail(frameEnd && dafFail),
    .safFail(frameEnd && safFail),
    .lenErr(frameEnd && lenMismatch && !ethType),
    .ovfErr(closeLast && ovfErr_ff),
    .vlan(frameEnd && vlanTag),
    .ipHdrErr(frameEnd && ipHdrErr),
    .lateCol(frameEnd && lateCollision &&
             ctrl_ff[CTRL_HALFDUP]),
    .ethType(frameEnd && ethType),
    .wdTimeout(closeLast && wdTimeout),
    .phyErr(closeLast && phyErr_ff),
    .dribble(frameEnd && oddNibble && ctrl_ff[CTRL_MII]),
    .crcErr(frameEnd && crcErr),
    .pcsumErr(frameEnd && pcsumErr),
    .word_ff(wbData_ff)
  );

endmodule
